/* design/chc_regs.svh */
`ifndef CHC_REGS_SVH
`define CHC_REGS_SVH

// Register indices; byte address is four times the index
`define CHC_IDX_DIV0_CNT 9'h190
`define CHC_IDX_DIV0_PHS 9'h191
`define CHC_IDX_DIV1_CNT 9'h193
`define CHC_IDX_DIV1_PHS 9'h194
`define CHC_IDX_DIV2_CNT 9'h196
`define CHC_IDX_DIV2_PHS 9'h197
`define CHC_IDX_DIV3_ST1 9'h199
`define CHC_IDX_DIV3_ST2 9'h19B
`define CHC_IDX_DIV3_BYP 9'h19C
`define CHC_IDX_DIV3_DUTY 9'h19D
`define CHC_IDX_DIV4_ST1 9'h19E
`define CHC_IDX_DIV4_ST2 9'h1A0
`define CHC_IDX_DIV4_BYP 9'h1A1
`define CHC_IDX_DIV4_DUTY 9'h1A2
`define CHC_IDX_OUT_CFG 9'h1F0
`define CHC_IDX_SYNC 9'h1F1
`define CHC_IDX_STATUS 9'h1F2

// Field positions
`define CHC_LOW_MSB 7
`define CHC_LOW_LSB 4
`define CHC_HIGH_MSB 3
`define CHC_HIGH_LSB 0
`define CHC_START_HIGH_BIT 4
`define CHC_PHASE_MSB 3
`define CHC_PHASE_LSB 0
`define CHC_BYP1_BIT 4
`define CHC_BYP2_BIT 5
`define CHC_DUTY_OFF_BIT 0
`define CHC_SYNC_BIT 0
`define CHC_D3_SE_BIT 0
`define CHC_D3_BEN_BIT 1
`define CHC_D4_SE_BIT 2
`define CHC_D4_BEN_BIT 3

// Reset value and phase limits
`define CHC_RST_REG 8'h00
`define CHC_PHASE_WRAP 6'h10
`define CHC_PHASE_MAX 6'h0F

`endif

/* design/chc_pkg.sv */
package chc_pkg;
    typedef enum logic [1:0] {
        CHC_DELAY = 2'b00,
        CHC_HIGH = 2'b01,
        CHC_LOW = 2'b11
    } chc_stage_e;
    typedef logic [7:0] chc_reg_t;
    typedef logic [5:0] chc_cnt_t;
endpackage

/* design/chc_top.sv */
// Local design decision: register access over APB.
`timescale 1ns/1ns
`include "chc_regs.svh"
// What this block does
// [R1] Start-high bit 4, phase bits 3:0
// [R2] Phase value sets rising-edge delay in cycles
// [R3] High field gives high part, low field low
// [R4] Phase delays are whole input cycles
// [R5] Dividers 3,4 drive pairs; B off by default (here reset selects differential mode, so B drives the complement)
// [R6] Dividers 3,4 cascade two 2-32 stages
// [R7] Bypassed stage divides by one
// [R8] Duty fix on after reset, off by bit
// [R9] Stage fields at documented register bits
// [R10] Fields store cycle count minus one
// [R11] Overall division is product of stage sums
// [R12] Software uses first stage when only one
// [R13] Software sets even stages with equal fields
// [R14] Software sets odd stages low one greater
// [R15] Single bypassed or even stage is second
// [R16] Fix off: last active stage sets duty
// [R17] Fix off, both bypassed: input duty passes (here A is held low and DIV3_PASS_OUT/DIV4_PASS_OUT go high instead)
// [R18] Fix on with valid counts gives half duty
// [R19] Phase takes effect only at synchronization
// [R20] Delay counted against zero-offset divider
// [R21] Stage counter: high run, then low run
module chc_top (
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    output logic DIV0_OUT,
    output logic DIV1_OUT,
    output logic DIV2_OUT,
    output logic DIV3_A_OUT,
    output logic DIV3_B_OUT,
    output logic DIV3_PASS_OUT,
    output logic DIV4_A_OUT,
    output logic DIV4_B_OUT,
    output logic DIV4_PASS_OUT
);
    localparam int NSLOT = 15;
    localparam int NST = 7;

    // Slot index of each stored register, or NSLOT when not stored
    function automatic logic [3:0] slot_of(input logic [8:0] idx);
        case (idx)
            `CHC_IDX_DIV0_CNT: slot_of = 4'h0;
            `CHC_IDX_DIV0_PHS: slot_of = 4'h1;
            `CHC_IDX_DIV1_CNT: slot_of = 4'h2;
            `CHC_IDX_DIV1_PHS: slot_of = 4'h3;
            `CHC_IDX_DIV2_CNT: slot_of = 4'h4;
            `CHC_IDX_DIV2_PHS: slot_of = 4'h5;
            `CHC_IDX_DIV3_ST1: slot_of = 4'h6;
            `CHC_IDX_DIV3_ST2: slot_of = 4'h7;
            `CHC_IDX_DIV3_BYP: slot_of = 4'h8;
            `CHC_IDX_DIV3_DUTY: slot_of = 4'h9;
            `CHC_IDX_DIV4_ST1: slot_of = 4'hA;
            `CHC_IDX_DIV4_ST2: slot_of = 4'hB;
            `CHC_IDX_DIV4_BYP: slot_of = 4'hC;
            `CHC_IDX_DIV4_DUTY: slot_of = 4'hD;
            `CHC_IDX_OUT_CFG: slot_of = 4'hE;
            default: slot_of = 4'hF;
        endcase
    endfunction

    // Phase value: below 16 is a plain delay, 16 and up wraps past the low run
    function automatic chc_pkg::chc_cnt_t phase_delay(input chc_pkg::chc_reg_t ps, input logic [3:0] low);
        chc_pkg::chc_cnt_t phi;
        phi = {1'b0, ps[`CHC_START_HIGH_BIT], ps[`CHC_PHASE_MSB:`CHC_PHASE_LSB]}; // [R1]
        if (phi <= `CHC_PHASE_MAX) begin
            phase_delay = phi; // [R2]
        end else begin
            phase_delay = phi - `CHC_PHASE_WRAP + {2'b00, low} + 6'h01; // [R2]
        end
    endfunction

    // High run length; the fix splits the period in halves
    function automatic chc_pkg::chc_cnt_t high_len(input chc_pkg::chc_reg_t c, input logic fix);
        chc_pkg::chc_cnt_t tot;
        tot = {2'b00, c[`CHC_HIGH_MSB:`CHC_HIGH_LSB]} + {2'b00, c[`CHC_LOW_MSB:`CHC_LOW_LSB]} + 6'h02; // [R10]
        high_len = fix ? {1'b0, tot[5:1]} : {2'b00, c[`CHC_HIGH_MSB:`CHC_HIGH_LSB]} + 6'h01; // [R3]
    endfunction

    function automatic chc_pkg::chc_cnt_t low_len(input chc_pkg::chc_reg_t c, input logic fix);
        chc_pkg::chc_cnt_t tot;
        tot = {2'b00, c[`CHC_HIGH_MSB:`CHC_HIGH_LSB]} + {2'b00, c[`CHC_LOW_MSB:`CHC_LOW_LSB]} + 6'h02;
        low_len = tot - high_len(c, fix); // [R10]
    endfunction

    chc_pkg::chc_reg_t regs_ff [NSLOT];
    logic sync_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;

    // APB decode
    wire logic [8:0] bus_idx = PADDR_IN[10:2];
    wire logic [3:0] bus_slot = slot_of(bus_idx);
    wire logic addr_ok = (PADDR_IN[11] == 1'b0) && (PADDR_IN[1:0] == 2'b00);
    wire logic is_stored = addr_ok && (bus_slot != 4'hF);
    wire logic is_sync = addr_ok && (bus_idx == `CHC_IDX_SYNC);
    wire logic is_status = addr_ok && (bus_idx == `CHC_IDX_STATUS);
    wire logic bus_hit = is_stored || is_sync || is_status;
    wire logic in_access = PSEL_IN && PENABLE_IN;
    wire logic first_access = in_access && !pready_ff;
    wire logic wr_done = in_access && pready_ff && PWRITE_IN;

    // Stage configuration: 0..2 single, 3/4 are divider 3, 5/6 divider 4
    chc_pkg::chc_stage_e state_ff [NST];
    chc_pkg::chc_cnt_t cnt_ff [NST];
    chc_pkg::chc_stage_e nxt_state [NST];
    chc_pkg::chc_cnt_t nxt_cnt [NST];
    chc_pkg::chc_reg_t st_cfg [NST];
    logic [NST-1:0] st_fix;
    logic [NST-1:0] st_tick;
    logic [NST-1:0] st_rise;
    logic [NST-1:0] st_lvl;
    chc_pkg::chc_cnt_t st_delay [NST];

    wire logic d3_byp1 = regs_ff[8][`CHC_BYP1_BIT];
    wire logic d3_byp2 = regs_ff[8][`CHC_BYP2_BIT];
    wire logic d4_byp1 = regs_ff[12][`CHC_BYP1_BIT];
    wire logic d4_byp2 = regs_ff[12][`CHC_BYP2_BIT];
    wire logic d3_fix = !regs_ff[9][`CHC_DUTY_OFF_BIT]; // [R8]
    wire logic d4_fix = !regs_ff[13][`CHC_DUTY_OFF_BIT]; // [R8]

    assign st_cfg[0] = regs_ff[0];
    assign st_cfg[1] = regs_ff[2];
    assign st_cfg[2] = regs_ff[4];
    assign st_cfg[3] = regs_ff[6]; // [R9]
    assign st_cfg[4] = regs_ff[7]; // [R9]
    assign st_cfg[5] = regs_ff[10]; // [R9]
    assign st_cfg[6] = regs_ff[11]; // [R9]
    // Dividers 0..2 have no disable bit in this map, so the fix stays on
    assign st_fix = {d4_fix, d4_fix, d3_fix, d3_fix, 3'b111};
    assign st_delay[0] = phase_delay(regs_ff[1], regs_ff[0][`CHC_LOW_MSB:`CHC_LOW_LSB]);
    assign st_delay[1] = phase_delay(regs_ff[3], regs_ff[2][`CHC_LOW_MSB:`CHC_LOW_LSB]);
    assign st_delay[2] = phase_delay(regs_ff[5], regs_ff[4][`CHC_LOW_MSB:`CHC_LOW_LSB]);
    assign st_delay[3] = 6'h00;
    assign st_delay[4] = 6'h00;
    assign st_delay[5] = 6'h00;
    assign st_delay[6] = 6'h00;
    // Second stage steps once per first-stage period, or per cycle if first is bypassed
    assign st_tick = {d4_byp1 ? 1'b1 : st_rise[5], 1'b1, d3_byp1 ? 1'b1 : st_rise[3], 4'b1111}; // [R6] [R11]

    genvar gs;
    generate
        for (gs = 0; gs < NST; gs++) begin : g_stage
            always_comb begin
                nxt_state[gs] = state_ff[gs];
                nxt_cnt[gs] = cnt_ff[gs];
                if (sync_ff) begin
                    // Restart aligned; a delayed stage idles low first
                    if (st_delay[gs] == 6'h00) begin // [R19] [R20]
                        nxt_state[gs] = chc_pkg::CHC_HIGH;
                        nxt_cnt[gs] = high_len(st_cfg[gs], st_fix[gs]) - 6'h01;
                    end else begin
                        nxt_state[gs] = chc_pkg::CHC_DELAY; // [R4]
                        nxt_cnt[gs] = st_delay[gs] - 6'h01;
                    end
                end else if (st_tick[gs]) begin
                    case (state_ff[gs])
                        chc_pkg::CHC_DELAY: begin
                            if (cnt_ff[gs] == 6'h00) begin
                                nxt_state[gs] = chc_pkg::CHC_HIGH;
                                nxt_cnt[gs] = high_len(st_cfg[gs], st_fix[gs]) - 6'h01;
                            end else begin
                                nxt_cnt[gs] = cnt_ff[gs] - 6'h01;
                            end
                        end
                        chc_pkg::CHC_HIGH: begin
                            if (cnt_ff[gs] == 6'h00) begin // [R21]
                                nxt_state[gs] = chc_pkg::CHC_LOW;
                                nxt_cnt[gs] = low_len(st_cfg[gs], st_fix[gs]) - 6'h01;
                            end else begin
                                nxt_cnt[gs] = cnt_ff[gs] - 6'h01;
                            end
                        end
                        chc_pkg::CHC_LOW: begin
                            if (cnt_ff[gs] == 6'h00) begin // [R21]
                                nxt_state[gs] = chc_pkg::CHC_HIGH;
                                nxt_cnt[gs] = high_len(st_cfg[gs], st_fix[gs]) - 6'h01;
                            end else begin
                                nxt_cnt[gs] = cnt_ff[gs] - 6'h01;
                            end
                        end
                        default: begin
                            nxt_state[gs] = chc_pkg::CHC_DELAY;
                            nxt_cnt[gs] = 6'h00;
                        end
                    endcase
                end
            end

            assign st_lvl[gs] = (state_ff[gs] == chc_pkg::CHC_HIGH);
            assign st_rise[gs] = st_tick[gs] && !sync_ff && !st_lvl[gs] && (nxt_state[gs] == chc_pkg::CHC_HIGH);

            always_ff @(posedge CLK_IN) begin
                if (!RST_N_IN) begin
                    state_ff[gs] <= chc_pkg::CHC_DELAY;
                    cnt_ff[gs] <= 6'h00;
                end else begin
                    state_ff[gs] <= nxt_state[gs];
                    cnt_ff[gs] <= nxt_cnt[gs];
                end
            end

            // Helper: length of the run just ended, in stage steps
            chc_pkg::chc_cnt_t run_ff;
            // Settings the run was loaded with; a later write only applies at the next reload
            chc_pkg::chc_reg_t cfg_at_ff;
            logic fix_at_ff;
            chc_pkg::chc_cnt_t dly_at_ff;
            wire logic run_restart = sync_ff || (st_tick[gs] && nxt_state[gs] != state_ff[gs]);
            always_ff @(posedge CLK_IN) begin
                if (!RST_N_IN || run_restart) begin
                    run_ff <= 6'h01;
                end else if (st_tick[gs]) begin
                    run_ff <= run_ff + 6'h01;
                end
            end
            always_ff @(posedge CLK_IN) begin
                if (!RST_N_IN) begin
                    cfg_at_ff <= `CHC_RST_REG;
                    fix_at_ff <= 1'b1;
                    dly_at_ff <= 6'h00;
                end else if (run_restart) begin
                    cfg_at_ff <= st_cfg[gs];
                    fix_at_ff <= st_fix[gs];
                    dly_at_ff <= st_delay[gs];
                end
            end

            chk_high_run: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [R3]
                (st_tick[gs] && !sync_ff && state_ff[gs] == chc_pkg::CHC_HIGH
                 && nxt_state[gs] == chc_pkg::CHC_LOW)
                |-> run_ff == high_len(cfg_at_ff, fix_at_ff))
                else $error("high run length wrong");
            chk_low_run: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [R10]
                (st_tick[gs] && !sync_ff && state_ff[gs] == chc_pkg::CHC_LOW
                 && nxt_state[gs] == chc_pkg::CHC_HIGH)
                |-> run_ff == low_len(cfg_at_ff, fix_at_ff))
                else $error("low run length wrong");
            if (gs < 3) begin : g_phase
                chk_phase_delay: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [R2]
                    (st_tick[gs] && !sync_ff && state_ff[gs] == chc_pkg::CHC_DELAY
                     && nxt_state[gs] == chc_pkg::CHC_HIGH)
                    |-> run_ff == dly_at_ff)
                    else $error("phase delay wrong");
            end
        end
    endgenerate

    chk_stage_step: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [R6]
        (!sync_ff && !st_tick[4]) |=> $stable(state_ff[4]) && $stable(cnt_ff[4]))
        else $error("second stage moved without a step");

    // Output selection: last active stage drives the pair
    wire logic d3_pass = d3_byp1 && d3_byp2; // [R7]
    wire logic d4_pass = d4_byp1 && d4_byp2; // [R7]
    wire logic d3_lvl = d3_pass ? 1'b0 : (d3_byp2 ? st_lvl[3] : st_lvl[4]); // [R16] [R17] [R18]
    wire logic d4_lvl = d4_pass ? 1'b0 : (d4_byp2 ? st_lvl[5] : st_lvl[6]); // [R16] [R17] [R18]
    wire chc_pkg::chc_reg_t out_cfg = regs_ff[14];
    // Differential mode drives B as the complement, low in pass-through; single-ended B only if enabled
    wire logic d3_b = out_cfg[`CHC_D3_SE_BIT] ? (out_cfg[`CHC_D3_BEN_BIT] && d3_lvl) : (!d3_pass && !d3_lvl); // [R5]
    wire logic d4_b = out_cfg[`CHC_D4_SE_BIT] ? (out_cfg[`CHC_D4_BEN_BIT] && d4_lvl) : (!d4_pass && !d4_lvl); // [R5]

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            DIV0_OUT <= 1'b0;
            DIV1_OUT <= 1'b0;
            DIV2_OUT <= 1'b0;
            DIV3_A_OUT <= 1'b0;
            DIV3_B_OUT <= 1'b0;
            DIV3_PASS_OUT <= 1'b0;
            DIV4_A_OUT <= 1'b0;
            DIV4_B_OUT <= 1'b0;
            DIV4_PASS_OUT <= 1'b0;
        end else begin
            DIV0_OUT <= st_lvl[0];
            DIV1_OUT <= st_lvl[1];
            DIV2_OUT <= st_lvl[2];
            DIV3_A_OUT <= d3_lvl;
            DIV3_B_OUT <= d3_b;
            DIV3_PASS_OUT <= d3_pass;
            DIV4_A_OUT <= d4_lvl;
            DIV4_B_OUT <= d4_b;
            DIV4_PASS_OUT <= d4_pass;
        end
    end

    chk_pass_out: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [R7]
        (d3_byp1 && d3_byp2) |=> DIV3_PASS_OUT && !DIV3_A_OUT)
        else $error("divider 3 pass flag wrong");
    chk_b_default: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [R5]
        (out_cfg[`CHC_D4_SE_BIT] && !out_cfg[`CHC_D4_BEN_BIT]) |=> !DIV4_B_OUT)
        else $error("single-ended B driven while off");
    chk_out_follow: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // [R16]
        (!d3_byp2 && !d3_byp1) |=> DIV3_A_OUT == $past(st_lvl[4]))
        else $error("divider 3 not from second stage");

    // Register file; sync request is self-clearing and fires once after reset
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            for (int i = 0; i < NSLOT; i++) begin
                regs_ff[i] <= `CHC_RST_REG; // [R8]
            end
            sync_ff <= 1'b1;
        end else begin
            if (wr_done && is_stored) begin
                regs_ff[bus_slot] <= PWDATA_IN[7:0];
            end
            sync_ff <= wr_done && is_sync && PWDATA_IN[`CHC_SYNC_BIT]; // [R19]
        end
    end

    chk_fix_reset: assert property (@(posedge CLK_IN) // [R8]
        $rose(RST_N_IN) |-> d3_fix && d4_fix && sync_ff)
        else $error("duty fix not on after reset");

    // One wait state: the answer comes on the second access cycle
    wire logic [31:0] rd_val = is_stored ? {24'h00_0000, regs_ff[bus_slot]}
        : (is_status ? {25'h000_0000, st_lvl} : 32'h0000_0000);

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            pready_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= first_access;
            prdata_ff <= (first_access && !PWRITE_IN) ? rd_val : 32'h0000_0000;
            pslverr_ff <= first_access && !bus_hit;
        end
    end

    assign PREADY_OUT = pready_ff;
    assign PRDATA_OUT = prdata_ff;
    assign PSLVERR_OUT = pslverr_ff;

    chk_apb_wait: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        (PSEL_IN && PENABLE_IN && !PREADY_OUT) |=> PREADY_OUT)
        else $error("no answer one cycle into access");
    chk_unmapped_err: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        (PSEL_IN && PENABLE_IN && !PREADY_OUT && !bus_hit) |=> PSLVERR_OUT && PRDATA_OUT == 32'h0000_0000)
        else $error("unmapped access not flagged");

endmodule

/* tb/chc_out_meter.sv */
`timescale 1ns/1ns
// Receiver stand-in: after arming, times the first full period that follows a fresh rising edge
module chc_out_meter (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic arm_in,
    input wire logic sig_in,
    output logic done_out,
    output logic [15:0] rise_out,
    output logic [15:0] hi_out,
    output logic [15:0] lo_out
);
    logic [15:0] t_ff;
    logic prev_ff;
    logic [1:0] st_ff;
    always_ff @(posedge clk_in) begin
        done_out <= 1'b0;
        t_ff <= t_ff + 16'h0001;
        prev_ff <= sig_in;
        if (!rst_n_in || arm_in) begin
            t_ff <= 16'h0000;
            st_ff <= 2'h0;
            // A level already high at arming is not a rise
            prev_ff <= 1'b1;
        end else if (st_ff == 2'h0 && sig_in && !prev_ff) begin
            rise_out <= t_ff;
            hi_out <= 16'h0001;
            st_ff <= 2'h1;
        end else if (st_ff == 2'h1) begin
            if (sig_in) begin
                hi_out <= hi_out + 16'h0001;
            end else begin
                lo_out <= 16'h0001;
                st_ff <= 2'h2;
            end
        end else if (st_ff == 2'h2) begin
            if (sig_in) begin
                done_out <= 1'b1;
                st_ff <= 2'h3;
            end else begin
                lo_out <= lo_out + 16'h0001;
            end
        end
    end
endmodule

/* tb/tb_chc_top.sv */
`timescale 1ns/1ns
`include "chc_regs.svh"
module tb_chc_top;
    logic CLK_IN = 1'b0;
    logic RST_N_IN = 1'b0;
    logic PSEL_IN = 1'b0;
    logic PENABLE_IN = 1'b0;
    logic PWRITE_IN = 1'b0;
    logic [11:0] PADDR_IN = 12'h000;
    logic [31:0] PWDATA_IN = 32'h0000_0000;
    logic [31:0] PRDATA_OUT;
    logic PREADY_OUT, PSLVERR_OUT, DIV0_OUT, DIV1_OUT, DIV2_OUT;
    logic DIV3_A_OUT, DIV3_B_OUT, DIV3_PASS_OUT, DIV4_A_OUT, DIV4_B_OUT, DIV4_PASS_OUT;
    logic arm = 1'b0;
    logic phase_mode = 1'b0;
    wire logic [3:0] sigs;
    wire logic [3:0] m_done;
    wire logic [3:0][15:0] m_rise, m_hi, m_lo;
    logic [31:0] q_rd[$], q0[$], q1[$], q3[$], q4[$];
    int err_total = 0;
    int comparisons = 0;
    logic [8:0] regs[14] = '{`CHC_IDX_DIV0_CNT, `CHC_IDX_DIV0_PHS, `CHC_IDX_DIV1_CNT, `CHC_IDX_DIV1_PHS,
        `CHC_IDX_DIV2_CNT, `CHC_IDX_DIV2_PHS, `CHC_IDX_DIV3_ST1, `CHC_IDX_DIV3_ST2, `CHC_IDX_DIV3_BYP,
        `CHC_IDX_DIV3_DUTY, `CHC_IDX_DIV4_ST1, `CHC_IDX_DIV4_ST2, `CHC_IDX_DIV4_BYP, `CHC_IDX_DIV4_DUTY};
    logic [3:0] h, l, h2, l2;
    logic [7:0] v;
    logic [4:0] p;
    logic [15:0] d1, dl, dd;
    logic acc, acc2;
    always #2 CLK_IN = ~CLK_IN;
    chc_top i_dut (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
        .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT),
        .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .DIV0_OUT(DIV0_OUT), .DIV1_OUT(DIV1_OUT),
        .DIV2_OUT(DIV2_OUT), .DIV3_A_OUT(DIV3_A_OUT), .DIV3_B_OUT(DIV3_B_OUT), .DIV3_PASS_OUT(DIV3_PASS_OUT),
        .DIV4_A_OUT(DIV4_A_OUT), .DIV4_B_OUT(DIV4_B_OUT), .DIV4_PASS_OUT(DIV4_PASS_OUT));
    assign sigs = {DIV4_A_OUT, DIV3_A_OUT, DIV1_OUT, DIV0_OUT};
    for (genvar g = 0; g < 4; g++) begin : g_m
        chc_out_meter i_m (.clk_in(CLK_IN), .rst_n_in(RST_N_IN), .arm_in(arm), .sig_in(sigs[g]),
            .done_out(m_done[g]), .rise_out(m_rise[g]), .hi_out(m_hi[g]), .lo_out(m_lo[g]));
    end
    task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic cmp_bit(input logic e, input logic g);
        cmp_word({31'h0, e}, {31'h0, g});
    endtask
    task automatic apb(input logic wr, input logic [8:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        PSEL_IN <= 1'b1;
        PENABLE_IN <= 1'b0;
        PWRITE_IN <= wr;
        PADDR_IN <= {1'b0, idx, 2'b00};
        PWDATA_IN <= {24'h00_0000, wd};
        @(posedge CLK_IN);
        PENABLE_IN <= 1'b1;
        do begin
            @(posedge CLK_IN);
            #1;
            n++;
        end while (PREADY_OUT !== 1'b1 && n < 64);
        if (n >= 64) err_total++;
        @(posedge CLK_IN);
        PSEL_IN <= 1'b0;
        PENABLE_IN <= 1'b0;
        @(posedge CLK_IN);
    endtask
    task automatic wr(input logic [8:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask
    task automatic rd(input logic [8:0] idx, input logic [31:0] e);
        q_rd.push_back(e);
        apb(1'b0, idx, 8'h00);
    endtask
    // Arms every meter, then waits until all noted periods have been seen
    task automatic measure();
        int n;
        n = 0;
        arm <= 1'b1;
        @(posedge CLK_IN);
        arm <= 1'b0;
        while ((q0.size() + q1.size() + q3.size() + q4.size()) != 0 && n < 5000) begin
            @(posedge CLK_IN);
            n++;
        end
        if (n >= 5000) err_total++;
    endtask
    // B checked against A every cycle for one output mode; divider 2 mirrors divider 0
    task automatic scan_b(input logic [7:0] cfg);
        wr(`CHC_IDX_OUT_CFG, cfg);
        acc = 1'b0;
        acc2 = 1'b0;
        repeat (40) begin
            @(posedge CLK_IN);
            #1;
            acc = acc | (DIV4_B_OUT ^ (cfg[2] ? (cfg[3] & DIV4_A_OUT) : ~DIV4_A_OUT));
            acc = acc | (DIV3_B_OUT ^ (cfg[0] ? (cfg[1] & DIV3_A_OUT) : ~DIV3_A_OUT));
            acc2 = acc2 | (DIV2_OUT ^ DIV0_OUT);
        end
        cmp_bit(1'b0, acc);
        cmp_bit(1'b0, acc2);
    endtask
    task automatic summarize();
        $display("Comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge CLK_IN) begin
        if (PSEL_IN && PENABLE_IN && PREADY_OUT === 1'b1 && !PWRITE_IN && q_rd.size() != 0) begin
            cmp_word(q_rd.pop_front(), {PSLVERR_OUT, PRDATA_OUT[30:0]});
        end
        // A done pulse seen at the arming edge belongs to the previous setup
        if (!arm) begin
            if (m_done[0] === 1'b1 && q0.size() != 0) cmp_word(q0.pop_front(), {m_hi[0], m_lo[0]});
            if (m_done[1] === 1'b1 && q1.size() != 0) begin
                // Offset taken modulo the 16-cycle period of the reference divider
                cmp_word(q1.pop_front(), phase_mode ? {28'h000_0000, m_rise[1][3:0] - m_rise[0][3:0]} : 32'h0);
            end
            if (m_done[2] === 1'b1 && q3.size() != 0) cmp_word(q3.pop_front(), {m_hi[2], m_lo[2]});
            if (m_done[3] === 1'b1 && q4.size() != 0) cmp_word(q4.pop_front(), {m_hi[3], m_lo[3]});
        end
    end
    initial begin
        #360000;
        err_total++;
        summarize();
    end
    initial begin
        void'($urandom(32'h8c4d_c09d));
        repeat (5) @(posedge CLK_IN);
        RST_N_IN <= 1'b1;
        @(posedge CLK_IN);
        for (int i = 0; i < 14; i++) rd(regs[i], 32'h0000_0000);
        rd(9'h192, 32'h8000_0000);
        rd(`CHC_IDX_SYNC, 32'h0000_0000);
        for (int i = 0; i < 14; i++) begin
            v = 8'($urandom());
            wr(regs[i], v);
            rd(regs[i], {24'h00_0000, v});
        end
        $display("Test registers done");
        wr(`CHC_IDX_DIV0_CNT, 8'h77);
        wr(`CHC_IDX_DIV1_CNT, 8'h77);
        wr(`CHC_IDX_DIV2_CNT, 8'h77);
        wr(`CHC_IDX_DIV0_PHS, 8'h00);
        wr(`CHC_IDX_DIV2_PHS, 8'h00);
        phase_mode = 1'b1;
        for (int i = 0; i < 6; i++) begin
            p = (i == 0) ? 5'h0F : (i == 3) ? 5'h10 : (i < 3) ? 5'(1 + $urandom_range(13)) : 5'(17 + $urandom_range(5));
            d1 = (p <= 5'h0F) ? 16'(p) : 16'(p - 5'h10 + 5'h08);
            wr(`CHC_IDX_DIV1_PHS, {3'h0, p});
            // Last pass skips the resync, so the old offset must remain
            if (i < 5) begin
                dl = d1;
                wr(`CHC_IDX_SYNC, 8'h01);
            end
            q0.push_back(32'h0008_0008);
            q1.push_back({16'h0000, 12'h000, dl[3:0]});
            measure();
        end
        phase_mode = 1'b0;
        $display("Test phase offset done");
        wr(`CHC_IDX_DIV3_BYP, 8'h20);
        wr(`CHC_IDX_DIV4_BYP, 8'h20);
        wr(`CHC_IDX_DIV3_DUTY, 8'h01);
        wr(`CHC_IDX_DIV4_DUTY, 8'h00);
        for (int i = 0; i < 8; i++) begin
            h = 4'($urandom());
            l = 4'($urandom());
            h2 = 4'($urandom_range(14));
            l2 = h2 + {3'h0, i[0]};
            if (i >= 4) begin
                wr(`CHC_IDX_DIV3_BYP, 8'h00);
                wr(`CHC_IDX_DIV4_BYP, 8'h00);
                l2 = h2;
            end
            wr(`CHC_IDX_DIV3_ST1, {l, h});
            // Odd first stage, even second: the split that keeps half duty
            wr(`CHC_IDX_DIV4_ST1, (i >= 4) ? {(h & 4'hE) + 4'h1, h & 4'hE} : {l2, h2});
            if (i >= 4) begin
                wr(`CHC_IDX_DIV3_ST2, {l2, h2});
                wr(`CHC_IDX_DIV4_ST2, {l2, h2});
            end
            // Notes follow the resync, so no period of the old setup is matched
            wr(`CHC_IDX_SYNC, 8'h01);
            dd = 16'(h) + 16'(l) + 16'h0002;
            if (i < 4) begin
                q3.push_back({16'(h) + 16'h0001, 16'(l) + 16'h0001});
                q4.push_back({16'(h2) + 16'h0001, 16'(l2) + 16'h0001});
            end else begin
                q3.push_back({(16'(h2) + 16'h0001) * dd, (16'(l2) + 16'h0001) * dd});
                dd = 16'(h & 4'hE) + 16'(h & 4'hE) + 16'h0003;
                q4.push_back({(16'(h2) + 16'h0001) * dd, (16'(h2) + 16'h0001) * dd});
            end
            measure();
        end
        $display("Test cascade done");
        scan_b(8'h00);
        scan_b(8'h05);
        scan_b(8'h0F);
        wr(`CHC_IDX_DIV3_BYP, 8'h30);
        wr(`CHC_IDX_DIV4_BYP, 8'h30);
        wr(`CHC_IDX_SYNC, 8'h01);
        repeat (4) @(posedge CLK_IN);
        #1;
        cmp_bit(1'b1, DIV3_PASS_OUT);
        cmp_bit(1'b0, DIV3_A_OUT);
        cmp_bit(1'b1, DIV4_PASS_OUT);
        cmp_bit(1'b0, DIV4_A_OUT);
        cmp_bit(1'b0, DIV3_B_OUT | DIV4_B_OUT);
        @(posedge CLK_IN);
        $display("Test bypass and outputs done");
        summarize();
    end
endmodule
